// ---- hw/sorc_pkg.sv ----
`default_nettype none
package sorc_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] SORC_ADDR_SETUP   = 8'h32;
   localparam logic [7:0] SORC_ADDR_PD_THR  = 8'h33;
   localparam logic [7:0] SORC_ADDR_DIVIDER = 8'h34;
   localparam logic [7:0] SORC_ADDR_CTRL    = 8'h38;
   localparam logic [7:0] SORC_ADDR_LINES   = 8'h39;
   localparam logic [7:0] SORC_ADDR_APPLIED = 8'h3A;

   localparam logic [7:0] SORC_RST_SETUP    = 8'h00;
   localparam logic [5:0] SORC_RST_PD_THR   = 6'h00;
   localparam logic [2:0] SORC_RST_RATIO    = 3'h0;
   localparam logic [2:0] SORC_RST_USAGE    = 3'h0;

   localparam int SORC_CODE_LSB   = 0;
   localparam int SORC_MAG_LSB    = 4;
   localparam int SORC_THR_LSB    = 0;
   localparam int SORC_PD_LSB     = 4;
   localparam int SORC_CTRL_EN    = 0;
   localparam int SORC_CTRL_ERST  = 1;
   localparam int SORC_CTRL_FIRE  = 2;
   localparam int SORC_LINE_DP    = 0;
   localparam int SORC_LINE_DM    = 1;

   // ------------------------------------------------------------------
   // Response codes and reserved field values
   // ------------------------------------------------------------------
   localparam logic [3:0] SORC_RESP_NONE     = 4'h0;
   localparam logic [3:0] SORC_RESP_VOLT_DP  = 4'h1;
   localparam logic [3:0] SORC_RESP_VOLT_DM  = 4'h2;
   localparam logic [3:0] SORC_RESP_VOLT_BO  = 4'h3;
   localparam logic [3:0] SORC_RESP_RES_DP   = 4'h4;
   localparam logic [3:0] SORC_RESP_RSVD_A   = 4'h5;
   localparam logic [3:0] SORC_RESP_DIV_DP   = 4'h6;
   localparam logic [3:0] SORC_RESP_RES_DM   = 4'h7;
   localparam logic [3:0] SORC_RESP_RSVD_B   = 4'h8;
   localparam logic [3:0] SORC_RESP_DIV_DM   = 4'h9;
   localparam logic [3:0] SORC_RESP_SHORT    = 4'hA;
   localparam logic [3:0] SORC_RESP_RSVD_C   = 4'hB;
   localparam logic [3:0] SORC_RESP_DIV_BO   = 4'hC;
   localparam logic [3:0] SORC_RESP_RES_BO   = 4'hD;
   localparam logic [3:0] SORC_RESP_PD_CTRL  = 4'hE;
   localparam logic [3:0] SORC_RESP_PD_ALT   = 4'hF;

   localparam logic [1:0] SORC_LINES_NONE    = 2'h0;
   localparam logic [1:0] SORC_LINES_DP      = 2'h1;
   localparam logic [1:0] SORC_LINES_DM      = 2'h2;
   localparam logic [1:0] SORC_LINES_BOTH    = 2'h3;

   localparam logic [3:0] SORC_MAG_RSVD      = 4'hF;
   localparam logic [3:0] SORC_THR_RSVD      = 4'hF;
   localparam logic [2:0] SORC_RATIO_RSVD    = 3'h7;
   localparam logic [2:0] SORC_USAGE_KEEP    = 3'h0;
   localparam logic [2:0] SORC_USAGE_REMOVE  = 3'h7;

   // ------------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic volt;
      logic resGnd;
      logic divider;
      logic emuPulldown;
   } sorc_line_t;

   typedef struct packed {
      logic       valid;
      logic       legacy;
      logic [2:0] detectUsageA;
      logic [7:0] setup;
      logic [7:0] pdThr;
      logic [2:0] ratio;
   } sorc_load_t;

   typedef struct packed {
      logic [3:0] voltMag;
      logic [3:0] resMag;
      logic [3:0] divMag;
      logic [2:0] ratio;
      logic       ratioActive;
      logic [1:0] sinkCurrent;
      logic [3:0] threshold;
      logic       thresholdActive;
   } sorc_analog_t;

   typedef struct packed {
      logic [1:0] volt;
      logic [1:0] resGnd;
      logic [1:0] divider;
      logic [1:0] note;
      logic       shortLines;
      logic       pdCtrl;
      logic       withdraw;
      logic       reserved;
   } sorc_class_t;

endpackage
`default_nettype wire

// ---- hw/sorc_resp_decode.sv ----
`default_nettype none
module sorc_resp_decode (
   input  wire logic [3:0]             respCode,
   output var  sorc_pkg::sorc_class_t  respClass
);
   import sorc_pkg::*;

   always_comb begin
      respClass = '0;
      unique case (respCode)
         SORC_RESP_NONE:    respClass.withdraw   = 1'b1;
         SORC_RESP_VOLT_DP: respClass.volt       = SORC_LINES_DP;
         SORC_RESP_VOLT_DM: respClass.volt       = SORC_LINES_DM;
         SORC_RESP_VOLT_BO: respClass.volt       = SORC_LINES_BOTH;
         SORC_RESP_RES_DP:  respClass.resGnd     = SORC_LINES_DP;
         SORC_RESP_RES_DM:  respClass.resGnd     = SORC_LINES_DM;
         SORC_RESP_RES_BO:  respClass.resGnd     = SORC_LINES_BOTH;
         SORC_RESP_DIV_DP:  respClass.divider    = SORC_LINES_DP;
         SORC_RESP_DIV_DM:  respClass.divider    = SORC_LINES_DM;
         SORC_RESP_DIV_BO:  respClass.divider    = SORC_LINES_BOTH;
         SORC_RESP_SHORT:   respClass.shortLines = 1'b1;
         SORC_RESP_PD_CTRL,
         SORC_RESP_PD_ALT:  respClass.pdCtrl     = 1'b1;
         SORC_RESP_RSVD_A,
         SORC_RESP_RSVD_B,
         SORC_RESP_RSVD_C:  respClass.reserved   = 1'b1;
      endcase
      // The dual voltage code still keeps a fresh pull-down on D+ alone.
      respClass.note = respClass.volt | respClass.resGnd | respClass.divider;
      if (respClass.note == SORC_LINES_BOTH) begin
         respClass.note = (respClass.volt == SORC_LINES_BOTH) ? SORC_LINES_DP : SORC_LINES_NONE;
      end
   end
endmodule
`default_nettype wire

// ---- hw/sorc_top.sv ----
// The address-and-strobe port is this design's own decision.
`default_nettype none
// Functional notes
// - Code 0000 withdraws every earlier response from both data lines.
// - Codes 0001, 0010, 0011 drive a voltage on D+, D-, or both.
// - Codes 0100, 0111, 1101 tie a resistor to ground on D+, D-, both.
// - Codes 0110, 1001, 1100 place a divider midpoint on D+, D-, both.
// - Code 1110 keeps pull-downs on usage 000, drops on 111, else holds.
// - Code 1111 acts exactly like code 1110.
// - Single-line response keeps pull-down only on usage 000 and untouched line.
// - Divider ratio codes 000 to 110 select seven ratios; 111 is reserved.
// - Divider ratio matters only while a divider response is connected.
// - Divider ratio is not updated while a BC1.2 profile is applied.
// - Pull-down current and threshold are not updated under legacy profiles.
// - Upper bits 7-3 of the divider register read as zero.
// - A reserved code written into a field is dropped; old value stays.
// - Magnitude is decoded by the response type that the code selects.
module sorc_top (
   input  wire logic                     clk_sys,
   input  wire logic                     rst,
   input  wire logic [7:0]               regAddr,
   input  wire logic [7:0]               regWdata,
   input  wire logic                     regWrite,
   input  wire logic                     regRead,
   output logic      [7:0]               regRdata,
   input  wire sorc_pkg::sorc_load_t     profileLoad,
   input  wire logic                     emuResetPulse,
   input  wire logic                     stimulusPin,
   output var  sorc_pkg::sorc_line_t     dataPlusOutput,
   output var  sorc_pkg::sorc_line_t     dataMinusOutput,
   output logic                          lineShort,
   output var  sorc_pkg::sorc_analog_t   analogSetting
);
   import sorc_pkg::*;

   // ------------------------------------------------------------------
   // Configuration fields loaded by the emulation profile engine
   // ------------------------------------------------------------------
   logic [7:0] setupReg, setupNext;
   logic [5:0] pdThrReg, pdThrNext;
   logic [2:0] ratioReg, ratioNext;
   logic [2:0] usageReg, usageNext;
   logic       legacyReg, legacyNext;
   logic [3:0] newCode, newMag, newThr;

   always_comb begin
      newCode    = profileLoad.setup[SORC_CODE_LSB +: 4];
      newMag     = profileLoad.setup[SORC_MAG_LSB +: 4];
      newThr     = profileLoad.pdThr[SORC_THR_LSB +: 4];
      setupNext  = setupReg;
      pdThrNext  = pdThrReg;
      ratioNext  = ratioReg;
      usageNext  = usageReg;
      legacyNext = legacyReg;
      if (profileLoad.valid) begin
         usageNext  = profileLoad.detectUsageA;
         legacyNext = profileLoad.legacy;
         if (newCode != SORC_RESP_RSVD_A && newCode != SORC_RESP_RSVD_B &&
             newCode != SORC_RESP_RSVD_C) begin
            setupNext[SORC_CODE_LSB +: 4] = newCode;
         end
         if (newMag != SORC_MAG_RSVD) begin
            setupNext[SORC_MAG_LSB +: 4] = newMag;
         end
         // Legacy profiles leave the BC1.2 detect settings alone.
         if (!profileLoad.legacy) begin
            pdThrNext[SORC_PD_LSB +: 2] = profileLoad.pdThr[SORC_PD_LSB +: 2];
            if (newThr != SORC_THR_RSVD) begin
               pdThrNext[SORC_THR_LSB +: 4] = newThr;
            end
         end
         if (profileLoad.legacy && profileLoad.ratio != SORC_RATIO_RSVD) begin
            ratioNext = profileLoad.ratio;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         setupReg  <= SORC_RST_SETUP;
         pdThrReg  <= SORC_RST_PD_THR;
         ratioReg  <= SORC_RST_RATIO;
         usageReg  <= SORC_RST_USAGE;
         legacyReg <= 1'b0;
      end else begin
         setupReg  <= setupNext;
         pdThrReg  <= pdThrNext;
         ratioReg  <= ratioNext;
         usageReg  <= usageNext;
         legacyReg <= legacyNext;
      end
   end

   // ------------------------------------------------------------------
   // Control register and stimulus pin synchroniser
   // ------------------------------------------------------------------
   logic       enableReg, enableNext;
   logic [2:0] stimSyncReg, stimSyncNext;
   logic       ctrlWrite, fire, emuReset;

   always_comb begin
      ctrlWrite    = regWrite && regAddr == SORC_ADDR_CTRL;
      enableNext   = ctrlWrite ? regWdata[SORC_CTRL_EN] : enableReg;
      stimSyncNext = {stimSyncReg[1:0], stimulusPin};
      // Only the second and third stages feed the edge detector.
      fire         = (enableReg && stimSyncReg[1] && !stimSyncReg[2]) ||
                     (ctrlWrite && regWdata[SORC_CTRL_FIRE]);
      emuReset     = emuResetPulse || (ctrlWrite && regWdata[SORC_CTRL_ERST]);
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         enableReg   <= 1'b0;
         stimSyncReg <= 3'h0;
      end else begin
         enableReg   <= enableNext;
         stimSyncReg <= stimSyncNext;
      end
   end

   // ------------------------------------------------------------------
   // Response application per data line
   // ------------------------------------------------------------------
   sorc_class_t respClass;
   sorc_line_t  lineReg [2];
   sorc_line_t  lineNext [2];
   logic [1:0]  appliedReg, appliedNext;
   logic        shortReg, shortNext;

   sorc_resp_decode uDecode (
      .respCode  (setupReg[SORC_CODE_LSB +: 4]),
      .respClass (respClass)
   );

   for (genvar i = 0; i < 2; i++) begin : gLine
      logic hit;
      always_comb begin
         hit            = respClass.volt[i] || respClass.resGnd[i] || respClass.divider[i];
         lineNext[i]    = lineReg[i];
         appliedNext[i] = appliedReg[i];
         if (emuReset) begin
            lineNext[i]             = '0;
            lineNext[i].emuPulldown = 1'b1;
            appliedNext[i]          = 1'b0;
         end else if (fire) begin
            if (respClass.withdraw) begin
               lineNext[i].volt    = 1'b0;
               lineNext[i].resGnd  = 1'b0;
               lineNext[i].divider = 1'b0;
            end else if (respClass.pdCtrl) begin
               if (usageReg == SORC_USAGE_KEEP) begin
                  lineNext[i].emuPulldown = 1'b1;
               end else if (usageReg == SORC_USAGE_REMOVE) begin
                  lineNext[i].emuPulldown = 1'b0;
               end
            end else if (hit) begin
               lineNext[i].volt    = respClass.volt[i];
               lineNext[i].resGnd  = respClass.resGnd[i];
               lineNext[i].divider = respClass.divider[i];
               // A fresh line on usage 000 keeps its reset pull-down only if its respClass.note bit is set.
               lineNext[i].emuPulldown = lineReg[i].emuPulldown && respClass.note[i] &&
                                         usageReg == SORC_USAGE_KEEP &&
                                         !appliedReg[i];
               appliedNext[i] = 1'b1;
            end
         end
      end

      always_ff @(posedge clk_sys) begin
         if (rst) begin
            lineReg[i]    <= '0;
            appliedReg[i] <= 1'b0;
         end else begin
            lineReg[i]    <= lineNext[i];
            appliedReg[i] <= appliedNext[i];
         end
      end
   end

   // ------------------------------------------------------------------
   // Short and analog settings
   // ------------------------------------------------------------------
   sorc_analog_t analogReg, analogNext;
   logic [3:0]   magField;

   always_comb begin
      magField  = setupReg[SORC_MAG_LSB +: 4];
      shortNext = shortReg;
      if (emuReset || (fire && respClass.withdraw)) begin
         shortNext = 1'b0;
      end else if (fire && respClass.shortLines) begin
         shortNext = 1'b1;
      end
      analogNext = analogReg;
      if (fire && !emuReset) begin
         if (respClass.volt != SORC_LINES_NONE) begin
            analogNext.voltMag = magField;
         end
         if (respClass.resGnd != SORC_LINES_NONE) begin
            analogNext.resMag = magField;
         end
         if (respClass.divider != SORC_LINES_NONE) begin
            analogNext.divMag = magField;
         end
      end
      // The ratio is only presented while a divider is connected.
      analogNext.ratioActive = lineNext[SORC_LINE_DP].divider ||
                               lineNext[SORC_LINE_DM].divider;
      analogNext.ratio       = analogNext.ratioActive ? ratioReg : SORC_RST_RATIO;
      analogNext.sinkCurrent = pdThrReg[SORC_PD_LSB +: 2];
      analogNext.threshold   = pdThrReg[SORC_THR_LSB +: 4];
      analogNext.thresholdActive = usageReg != SORC_USAGE_KEEP &&
                                   usageReg != SORC_USAGE_REMOVE;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         shortReg  <= 1'b0;
         analogReg <= '0;
      end else begin
         shortReg  <= shortNext;
         analogReg <= analogNext;
      end
   end

   // ------------------------------------------------------------------
   // Register readback
   // ------------------------------------------------------------------
   logic [7:0] rdataReg, rdataNext;

   always_comb begin
      rdataNext = 8'h00;
      if (regRead) begin
         unique case (regAddr)
            SORC_ADDR_SETUP:   rdataNext = setupReg;
            SORC_ADDR_PD_THR:  rdataNext = {2'h0, pdThrReg};
            SORC_ADDR_DIVIDER: rdataNext = {5'h00, ratioReg};
            SORC_ADDR_CTRL:    rdataNext = {7'h00, enableReg};
            SORC_ADDR_LINES:   rdataNext = {lineReg[SORC_LINE_DM], lineReg[SORC_LINE_DP]};
            SORC_ADDR_APPLIED: rdataNext = {legacyReg, usageReg, 1'b0, shortReg, appliedReg};
            default:           rdataNext = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         rdataReg <= 8'h00;
      end else begin
         rdataReg <= rdataNext;
      end
   end

   assign regRdata        = rdataReg;
   assign dataPlusOutput  = lineReg[SORC_LINE_DP];
   assign dataMinusOutput = lineReg[SORC_LINE_DM];
   assign lineShort       = shortReg;
   assign analogSetting   = analogReg;

   // ------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   logic [3:0] heldCode;
   assign heldCode = setupReg[SORC_CODE_LSB +: 4];

   a_zero_withdraw: assert property (
      fire && !emuReset && heldCode == SORC_RESP_NONE |=>
         !dataPlusOutput.volt && !dataPlusOutput.resGnd && !dataPlusOutput.divider &&
         !dataMinusOutput.volt && !dataMinusOutput.resGnd && !dataMinusOutput.divider &&
         !lineShort)
      else $error("withdraw left a response on a line");
   a_volt_both: assert property (
      fire && !emuReset && heldCode == SORC_RESP_VOLT_BO |=>
         dataPlusOutput.volt && dataMinusOutput.volt && !dataPlusOutput.divider)
      else $error("voltage not driven on both lines");
   a_res_both: assert property (
      fire && !emuReset && heldCode == SORC_RESP_RES_BO |=>
         dataPlusOutput.resGnd && dataMinusOutput.resGnd && !dataMinusOutput.volt)
      else $error("ground resistor missing on a line");
   a_div_dplus: assert property (
      fire && !emuReset && heldCode == SORC_RESP_DIV_DP |=>
         dataPlusOutput.divider && dataMinusOutput == $past(dataMinusOutput))
      else $error("divider not placed on D+ alone");
   a_short_set: assert property (
      fire && !emuReset && heldCode == SORC_RESP_SHORT |=> lineShort)
      else $error("short not applied");
   a_pd_remove: assert property (
      fire && !emuReset && respClass.pdCtrl && usageReg == SORC_USAGE_REMOVE |=>
         !dataPlusOutput.emuPulldown && !dataMinusOutput.emuPulldown)
      else $error("pull-downs not removed");
   a_pd_alt_keep: assert property (
      fire && !emuReset && heldCode == SORC_RESP_PD_ALT && usageReg == SORC_USAGE_KEEP |=>
         dataPlusOutput.emuPulldown && dataMinusOutput.emuPulldown)
      else $error("alternate code did not keep pull-downs");
   a_pd_fresh_keep: assert property (
      fire && !emuReset && heldCode == SORC_RESP_RES_DP && usageReg == SORC_USAGE_KEEP &&
      !appliedReg[SORC_LINE_DP] && dataPlusOutput.emuPulldown |=>
         dataPlusOutput.emuPulldown && dataPlusOutput.resGnd)
      else $error("fresh line lost its pull-down");
   a_ratio_gate: assert property (
      !(dataPlusOutput.divider || dataMinusOutput.divider) |->
         !analogSetting.ratioActive && analogSetting.ratio == SORC_RST_RATIO)
      else $error("ratio presented without a divider");
   a_ratio_hold: assert property (
      profileLoad.valid && !profileLoad.legacy |=> $stable(ratioReg))
      else $error("ratio updated under a BC1.2 profile");
   a_thr_hold: assert property (
      profileLoad.valid && profileLoad.legacy |=> $stable(pdThrReg))
      else $error("detect settings updated under a legacy profile");
   a_div_upper: assert property (
      regRead && regAddr == SORC_ADDR_DIVIDER |=>
         regRdata[7:3] == 5'h00 ##1 ($past(regRead) || regRdata == 8'h00))
      else $error("divider upper bits not zero");
   a_rsvd_reject: assert property (
      profileLoad.valid && profileLoad.ratio == SORC_RATIO_RSVD |=> $stable(ratioReg))
      else $error("reserved ratio accepted");
   a_mag_volt: assert property (
      fire && !emuReset && respClass.volt != SORC_LINES_NONE |=>
         analogSetting.voltMag == $past(magField) && $stable(analogSetting.divMag))
      else $error("voltage magnitude not captured");
   a_sink_follow: assert property (
      1'b1 |=> analogSetting.sinkCurrent == $past(pdThrReg[SORC_PD_LSB +: 2]))
      else $error("sink current does not follow its field");

   c_divider_run: cover property (fire && respClass.divider == SORC_LINES_BOTH);
   c_short_run:   cover property (fire && respClass.shortLines ##[1:20] fire && respClass.withdraw);
   c_pd_remove:   cover property (fire && respClass.pdCtrl && usageReg == SORC_USAGE_REMOVE);
   c_rsvd_load:   cover property (profileLoad.valid && newCode == SORC_RESP_RSVD_B);

endmodule
`default_nettype wire

// ---- dv/sorc_device_model.sv ----
`default_nettype none
module sorc_device_model (
   input  wire logic       clk_sys,
   input  wire logic       stimReq,
   input  wire logic [3:0] stimDelay,
   output logic            stimulusPin
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------------------------
   // Portable device stimulus
   // ---------------------------------------------------------------
   // The level is held four cycles so that the three-flop synchroniser
   // cannot miss it, whatever the phase of the request.
   initial begin
      stimulusPin = 1'b0;
      forever begin
         @(posedge clk_sys iff stimReq);
         repeat (stimDelay) @(posedge clk_sys);
         stimulusPin <= 1'b1;
         repeat (4) @(posedge clk_sys);
         stimulusPin <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ---- dv/stimulus_one_response_config_tb_top.sv ----
`default_nettype none
module stimulus_one_response_config_tb_top;
   import sorc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [6:0] LINE_MAP [16] = '{7'h00, 7'h40, 7'h08, 7'h48, 7'h20, 7'h00,
      7'h10, 7'h04, 7'h00, 7'h02, 7'h01, 7'h00, 7'h12, 7'h24, 7'h00, 7'h00};
   logic         clk_sys, rst, regWrite, regRead, emuResetPulse, stimReq, stimulusPin;
   logic         lineShort, isDiv;
   logic [7:0]   regAddr, regWdata, regRdata, rdv, setupM, pdThrM;
   logic [3:0]   stimDelay;
   logic [2:0]   ratioM;
   logic [6:0]   linesSeen;
   logic [31:0]  rnd;
   int           errors, comparisons, w;
   int           usages [3] = '{0, 7, 3};
   sorc_load_t   profileLoad;
   sorc_line_t   dataPlusOutput, dataMinusOutput;
   sorc_analog_t analogSetting;

   assign linesSeen = {dataPlusOutput.volt, dataPlusOutput.resGnd, dataPlusOutput.divider,
      dataMinusOutput.volt, dataMinusOutput.resGnd, dataMinusOutput.divider, lineShort};

   sorc_top uut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .profileLoad(profileLoad),
      .emuResetPulse(emuResetPulse), .stimulusPin(stimulusPin), .dataPlusOutput(dataPlusOutput),
      .dataMinusOutput(dataMinusOutput), .lineShort(lineShort), .analogSetting(analogSetting));
   sorc_device_model dev (.clk_sys(clk_sys), .stimReq(stimReq), .stimDelay(stimDelay),
      .stimulusPin(stimulusPin));

   // ---------------------------------------------------------------
   // Bench tasks
   // ---------------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask

   task automatic end_of_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr  <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string what);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clk_sys);
      regRead <= 1'b0;
      #1 chk(regRdata, e, what);
   endtask

   // The model refuses reserved values field by field, as the device does.
   task automatic ld(input logic g, input int u, input logic [7:0] s, input logic [7:0] p,
                     input logic [2:0] r);
      @(posedge clk_sys);
      profileLoad <= '{valid: 1'b1, legacy: g, detectUsageA: 3'(u), setup: s, pdThr: p, ratio: r};
      @(posedge clk_sys);
      profileLoad.valid <= 1'b0;
      if (s[7:4] != SORC_MAG_RSVD) setupM[7:4] = s[7:4];
      if (!(s[3:0] inside {SORC_RESP_RSVD_A, SORC_RESP_RSVD_B, SORC_RESP_RSVD_C}))
         setupM[3:0] = s[3:0];
      if (g && r != SORC_RATIO_RSVD) ratioM = r;
      if (!g) pdThrM[5:4] = p[5:4];
      if (!g && p[3:0] != SORC_THR_RSVD) pdThrM[3:0] = p[3:0];
   endtask

   task automatic emu;
      @(posedge clk_sys);
      emuResetPulse <= 1'b1;
      @(posedge clk_sys);
      emuResetPulse <= 1'b0;
   endtask

   task automatic fire;
      wr(SORC_ADDR_CTRL, 8'h04);
      @(posedge clk_sys);
      #1;
   endtask

   task automatic stim(input logic [3:0] d, input logic e);
      @(posedge clk_sys);
      stimDelay <= d;
      stimReq   <= 1'b1;
      @(posedge clk_sys);
      stimReq <= 1'b0;
      for (w = 0; w < 30 && dataPlusOutput.volt !== 1'b1; w++) @(posedge clk_sys);
      #1 chk(dataPlusOutput.volt, e, "pin stimulus response");
   endtask

   // ---------------------------------------------------------------
   // Clock, reset, watchdog
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      end_of_test();
   end

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial begin
      {rst, regWrite, regRead, emuResetPulse, stimReq} = 5'b1_0000;
      {regAddr, regWdata, stimDelay, profileLoad} = '0;
      {setupM, pdThrM, ratioM} = '0;
      {errors, comparisons} = '0;
      rnd = 32'h0000_f342;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      rdchk(SORC_ADDR_SETUP, 8'h00, "setup reset");
      rdchk(SORC_ADDR_PD_THR, 8'h00, "threshold reset");
      rdchk(SORC_ADDR_DIVIDER, 8'h00, "divider reset");
      wr(SORC_ADDR_SETUP, 8'h3c);
      rdchk(SORC_ADDR_SETUP, 8'h00, "read-only setup");
      rdchk(8'h50, 8'h00, "unmapped read");
      $display("register access test finished");

      for (int r = 0; r < 8; r++) begin
         rnd = lfsr(rnd);
         ld(1'b1, 0, setupM, {2'b11, rnd[5:0]}, 3'(r));
         rdchk(SORC_ADDR_DIVIDER, {5'h00, ratioM}, "divider ratio");
         rdchk(SORC_ADDR_PD_THR, pdThrM, "legacy threshold hold");
      end
      $display("legacy profile test finished");

      // Descending order leaves code 0 to withdraw a live code 1 response.
      for (int c = 15; c >= 0; c--) begin
         rnd = lfsr(rnd);
         if (c != 0) emu();
         ld(1'b0, 0, {rnd[7:4], 4'(c)}, {2'b11, rnd[13:8]}, rnd[18:16]);
         rdchk(SORC_ADDR_SETUP, setupM, "setup load");
         rdchk(SORC_ADDR_PD_THR, pdThrM, "threshold load");
         rdchk(SORC_ADDR_DIVIDER, {5'h00, ratioM}, "divider hold");
         fire();
         chk(linesSeen, LINE_MAP[setupM[3:0]], "line response");
         isDiv = setupM[3:0] inside {SORC_RESP_DIV_DP, SORC_RESP_DIV_DM, SORC_RESP_DIV_BO};
         chk(analogSetting.ratioActive, isDiv, "ratio active");
         chk(analogSetting.ratio, isDiv ? ratioM : 3'h0, "ratio output");
         chk(analogSetting.sinkCurrent, pdThrM[5:4], "sink current");
         chk(analogSetting.threshold, pdThrM[3:0], "threshold");
         if (setupM[3:0] inside {4'h1, 4'h2, 4'h3})
            chk(analogSetting.voltMag, setupM[7:4], "voltage magnitude");
         if (setupM[3:0] inside {4'h4, 4'h7, 4'hd})
            chk(analogSetting.resMag, setupM[7:4], "resistor magnitude");
         if (setupM[3:0] inside {4'h6, 4'h9, 4'hc})
            chk(analogSetting.divMag, setupM[7:4], "divider magnitude");
         if (setupM[3:0] inside {4'h1, 4'h3, 4'h4, 4'h6})
            chk(dataPlusOutput.emuPulldown, 1'b1, "plus pull-down kept");
         if (setupM[3:0] inside {4'h2, 4'h7, 4'h9})
            chk(dataMinusOutput.emuPulldown, 1'b1, "minus pull-down kept");
      end
      $display("response code test finished");

      // Usage 111 before 011 shows that 011 leaves a removed pull-down removed.
      for (int k = 0; k < 6; k++) begin
         if (k % 3 == 0) emu();
         ld(1'b0, usages[k % 3], {4'h1, (k < 3) ? SORC_RESP_PD_CTRL : SORC_RESP_PD_ALT},
            pdThrM, 3'h0);
         fire();
         isDiv = (usages[k % 3] == 0);
         chk(analogSetting.thresholdActive, usages[k % 3] == 3, "threshold active");
         chk({dataPlusOutput.emuPulldown, dataMinusOutput.emuPulldown}, {isDiv, isDiv},
             "pull-down control");
         chk(linesSeen, 7'h00, "pull-down control lines");
      end
      $display("pull-down control test finished");

      emu();
      ld(1'b0, 0, {4'h2, SORC_RESP_VOLT_DP}, pdThrM, 3'h0);
      wr(SORC_ADDR_CTRL, 8'h01);
      rdchk(SORC_ADDR_CTRL, 8'h01, "control enable");
      stim(4'h0, 1'b1);
      wr(SORC_ADDR_CTRL, 8'h02);
      stim(4'h9, 1'b0);
      chk({dataPlusOutput.emuPulldown, dataMinusOutput.emuPulldown}, 2'b11,
          "emulation reset pull-downs");
      $display("stimulus pin test finished");
      end_of_test();
   end
endmodule
`default_nettype wire
